/* File: hdl/arb_if.sv */
`timescale 1ns/1ns
interface arb_if;
	import irq_ctrl_pkg::*;
	logic [NSRC-1:0]  pend;
	logic [NSRC-1:0]  grant;
	logic [IDX_W-1:0] idx;
	logic             valid;
	modport arbiter (input pend, output grant, idx, valid);
	modport ctrl    (output pend, input grant, idx, valid);
endinterface : arb_if

/* File: hdl/edge_sense.sv */
`timescale 1ns/1ns
module edge_sense #(
	parameter int LINES = 2
) (
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [LINES-1:0]   pin,
	input  wire logic [2*LINES-1:0] sel,
	output logic      [LINES-1:0]   pulse
);
	import irq_ctrl_pkg::*;

	logic [LINES-1:0] prev_q;
	logic [LINES-1:0] prev_d;

	always_comb begin
		prev_d = pin;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= '0;
		end else begin
			prev_q <= prev_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < LINES; g++) begin : g_line
			logic rise;
			logic fall;
			assign rise = pin[g] & ~prev_q[g];
			assign fall = ~pin[g] & prev_q[g];
			always_comb begin
				case (sel[2*g +: 2])
					EDGE_RISE: pulse[g] = rise;
					EDGE_FALL: pulse[g] = fall;
					EDGE_BOTH: pulse[g] = rise | fall;
					default:   pulse[g] = 1'b0;
				endcase
			end
		end
	endgenerate

endmodule : edge_sense

/* File: hdl/interrupt_request_controller.sv */
`timescale 1ns/1ns
module interrupt_request_controller #(
	parameter int              PC_W     = 16,
	parameter logic [PC_W-1:0] VEC_BASE = 16'h0004,
	parameter logic [PC_W-1:0] VEC_STEP = 16'h0004
) (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [irq_ctrl_pkg::WB_AW-1:0] wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic      [31:0]                 wb_dat_o,
	output logic                             wb_ack_o,
	input  wire logic [1:0]                  ext_irq_pin,
	input  wire logic                        tick0_evt,
	input  wire logic                        tick1_evt,
	input  wire logic                        low_supply_evt,
	input  wire logic                        conv_done_evt,
	input  wire logic [3:0]                  timer_match_evt,
	input  wire logic                        pulse_period_evt,
	input  wire logic [4:0]                  pulse_duty_evt,
	input  wire logic                        core_ready,
	input  wire logic                        call_ack,
	input  wire logic [PC_W-1:0]             pc_next,
	input  wire logic                        stack_full,
	input  wire logic                        return_from_irq_instr,
	output logic                             call_req,
	output logic      [PC_W-1:0]             call_vector,
	output logic                             stack_push,
	output logic      [PC_W-1:0]             push_data,
	output logic                             stack_pop,
	output logic                             wake
);
	import irq_ctrl_pkg::*;

	// ********************************
	// state
	// ********************************
	logic [REG_W-1:0] regs_q [NREG];
	logic [REG_W-1:0] regs_d [NREG];
	logic [REG_W-1:0] set_v  [NREG];
	logic [REG_W-1:0] clr_v  [NREG];
	call_state_t      state_q;
	call_state_t      state_d;
	logic             ack_q;
	logic             ack_d;
	logic [31:0]      rdat_q;
	logic [31:0]      rdat_d;
	logic             call_q;
	logic             call_d;
	logic [PC_W-1:0]  vec_q;
	logic [PC_W-1:0]  vec_d;
	logic             push_q;
	logic             push_d;
	logic [PC_W-1:0]  pdat_q;
	logic [PC_W-1:0]  pdat_d;
	logic             pop_q;
	logic             pop_d;
	logic             wake_q;
	logic             wake_d;
	logic [1:0]       ext_pulse;
	logic             accept;
	logic             req_take;
	logic             bus_wr;
	logic             hit;
	logic [2:0]       widx;

	arb_if arb ();

	// ********************************
	// sub blocks
	// ********************************
	edge_sense #(
		.LINES (2)
	) u_edge (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (ext_irq_pin),
		.sel   (regs_q[REG_EDGE][3:0]),
		.pulse (ext_pulse)
	);

	irq_arbiter u_arb (
		.arb (arb.arbiter)
	);

	// ********************************
	// wishbone slave
	// ********************************
	// unmapped words read zero and still ack, so a stray access never hangs
	assign widx     = wb_adr_i[4:2];
	assign hit      = (wb_adr_i[WB_AW-1:5] == '0) && (widx < 3'(NREG))
	                  && (wb_adr_i[1:0] == 2'h0);
	assign req_take = wb_cyc_i & wb_stb_i & ~ack_q;
	assign bus_wr   = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & hit
	                  & wb_sel_i[0];

	always_comb begin
		ack_d  = req_take;
		rdat_d = rdat_q;
		if (req_take) begin
			rdat_d = 32'h0000_0000;
			if (hit) begin
				rdat_d[REG_W-1:0] = regs_q[widx] & IMPL_MASK[widx];
			end
		end
	end

	// ********************************
	// acceptance
	// ********************************
	always_comb begin
		arb.pend = '0;
		arb.pend[SRC_EXT0]  = regs_q[REG_CTL0][B_EXT0_REQ]
		                      & regs_q[REG_CTL0][B_EXT0_EN];
		arb.pend[SRC_EXT1]  = regs_q[REG_CTL0][B_EXT1_REQ]
		                      & regs_q[REG_CTL0][B_EXT1_EN];
		arb.pend[SRC_GRP0]  = regs_q[REG_CTL0][B_GRP0_REQ]
		                      & regs_q[REG_CTL0][B_GRP0_EN];
		arb.pend[SRC_TICK0] = regs_q[REG_CTL1][B_TICK0_REQ]
		                      & regs_q[REG_CTL1][B_TICK0_EN];
		arb.pend[SRC_TICK1] = regs_q[REG_CTL1][B_TICK1_REQ]
		                      & regs_q[REG_CTL1][B_TICK1_EN];
		arb.pend[SRC_GRP1]  = regs_q[REG_CTL1][B_GRP1_REQ]
		                      & regs_q[REG_CTL1][B_GRP1_EN];
		arb.pend[SRC_GRP2]  = regs_q[REG_CTL1][B_GRP2_REQ]
		                      & regs_q[REG_CTL1][B_GRP2_EN];
		arb.pend[SRC_CONV]  = regs_q[REG_CTL2][B_CONV_REQ]
		                      & regs_q[REG_CTL2][B_CONV_EN];
		arb.pend[SRC_LOW]   = regs_q[REG_CTL2][B_LOW_REQ]
		                      & regs_q[REG_CTL2][B_LOW_EN];
	end

	// only at an instruction boundary, and never while a call is open
	assign accept = (state_q == ST_IDLE) & core_ready & arb.valid
	                & regs_q[REG_CTL0][B_GIE] & ~stack_full;

	// ********************************
	// flag and enable registers
	// ********************************
	always_comb begin
		for (int i = 0; i < NREG; i++) begin
			set_v[i] = '0;
			clr_v[i] = '0;
		end
		set_v[REG_CTL0][B_EXT0_REQ]  = ext_pulse[0];
		set_v[REG_CTL0][B_EXT1_REQ]  = ext_pulse[1];
		set_v[REG_CTL0][B_GRP0_REQ]  =
			member_pending(regs_q[REG_GTMR]);
		set_v[REG_CTL1][B_TICK0_REQ] = tick0_evt;
		set_v[REG_CTL1][B_TICK1_REQ] = tick1_evt;
		set_v[REG_CTL1][B_GRP1_REQ]  =
			member_pending(regs_q[REG_GPWA]);
		set_v[REG_CTL1][B_GRP2_REQ]  =
			member_pending(regs_q[REG_GPWB]);
		set_v[REG_CTL2][B_CONV_REQ]  = conv_done_evt;
		set_v[REG_CTL2][B_LOW_REQ]   = low_supply_evt;
		set_v[REG_GTMR][7:4] = timer_match_evt;
		set_v[REG_GPWA][7:4] = {pulse_duty_evt[2:0], pulse_period_evt};
		set_v[REG_GPWB][5:4] = pulse_duty_evt[4:3];
		// member flags are left alone: software clears them
		if (accept) begin
			case (arb.idx)
				SRC_EXT0:  clr_v[REG_CTL0][B_EXT0_REQ]  = 1'b1;
				SRC_EXT1:  clr_v[REG_CTL0][B_EXT1_REQ]  = 1'b1;
				SRC_GRP0:  clr_v[REG_CTL0][B_GRP0_REQ]  = 1'b1;
				SRC_TICK0: clr_v[REG_CTL1][B_TICK0_REQ] = 1'b1;
				SRC_TICK1: clr_v[REG_CTL1][B_TICK1_REQ] = 1'b1;
				SRC_GRP1:  clr_v[REG_CTL1][B_GRP1_REQ]  = 1'b1;
				SRC_GRP2:  clr_v[REG_CTL1][B_GRP2_REQ]  = 1'b1;
				SRC_CONV:  clr_v[REG_CTL2][B_CONV_REQ]  = 1'b1;
				SRC_LOW:   clr_v[REG_CTL2][B_LOW_REQ]   = 1'b1;
				default:   clr_v[REG_CTL0][B_GIE]       = 1'b0;
			endcase
		end
		for (int i = 0; i < NREG; i++) begin
			// hardware set beats a software or service clear
			regs_d[i] = ((((bus_wr && widx == 3'(i)) ? wb_dat_i[7:0]
			              : regs_q[i]) & ~clr_v[i]) | set_v[i])
			            & IMPL_MASK[i];
		end
		if (accept) begin
			regs_d[REG_CTL0][B_GIE] = 1'b0;
		end
	end

	always_comb begin
		wake_d = 1'b0;
		for (int i = 0; i < NREG; i++) begin
			if (|(regs_d[i] & ~regs_q[i] & FLAG_MASK[i])) begin
				wake_d = 1'b1;
			end
		end
	end

	// ********************************
	// call sequence
	// ********************************
	always_comb begin
		state_d = state_q;
		call_d  = call_q;
		vec_d   = vec_q;
		push_d  = 1'b0;
		pdat_d  = pdat_q;
		pop_d   = return_from_irq_instr;
		case (state_q)
			ST_IDLE: begin
				if (accept) begin
					state_d = ST_CALL;
					call_d  = 1'b1;
					vec_d   = PC_W'(VEC_BASE + PC_W'(arb.idx) * VEC_STEP);
					push_d  = 1'b1;
					pdat_d  = pc_next;
				end
			end
			ST_CALL: begin
				if (call_ack) begin
					state_d = ST_IDLE;
					call_d  = 1'b0;
				end
			end
			default: begin
				state_d = ST_IDLE;
				call_d  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NREG; i++) begin
				regs_q[i] <= REG_RESET;
			end
			state_q <= ST_IDLE;
			ack_q   <= 1'b0;
			rdat_q  <= 32'h0000_0000;
			call_q  <= 1'b0;
			vec_q   <= '0;
			push_q  <= 1'b0;
			pdat_q  <= '0;
			pop_q   <= 1'b0;
			wake_q  <= 1'b0;
		end else begin
			regs_q  <= regs_d;
			state_q <= state_d;
			ack_q   <= ack_d;
			rdat_q  <= rdat_d;
			call_q  <= call_d;
			vec_q   <= vec_d;
			push_q  <= push_d;
			pdat_q  <= pdat_d;
			pop_q   <= pop_d;
			wake_q  <= wake_d;
		end
	end

	assign wb_ack_o    = ack_q;
	assign wb_dat_o    = rdat_q;
	assign call_req    = call_q;
	assign call_vector = vec_q;
	assign stack_push  = push_q;
	assign push_data   = pdat_q;
	assign stack_pop   = pop_q;
	assign wake        = wake_q;

	// ********************************
	// checks
	// ********************************
	a_gie_blocks: assert property (@(posedge clk) disable iff (!rst_n)
		!regs_q[REG_CTL0][B_GIE] |-> !accept)
		else $error("accepted with global enable low");
	a_full_holds: assert property (@(posedge clk) disable iff (!rst_n)
		stack_full |-> !accept)
		else $error("accepted on full stack");
	a_gie_cleared: assert property (@(posedge clk) disable iff (!rst_n)
		accept |=> !regs_q[REG_CTL0][B_GIE])
		else $error("global enable not cleared on call");
	a_call_push: assert property (@(posedge clk) disable iff (!rst_n)
		accept |=> call_req && stack_push && push_data == $past(pc_next)
		&& call_vector == PC_W'(VEC_BASE + PC_W'($past(arb.idx)) * VEC_STEP))
		else $error("call, push or vector wrong");
	a_pop_follow: assert property (@(posedge clk) disable iff (!rst_n)
		return_from_irq_instr |=> stack_pop)
		else $error("no pop after return");
	a_grant_enabled: assert property (@(posedge clk) disable iff (!rst_n)
		accept |-> (arb.grant & arb.pend) != '0 && $onehot(arb.grant))
		else $error("granted a disabled source");
	a_ext0_cleared: assert property (@(posedge clk) disable iff (!rst_n)
		accept && arb.idx == SRC_EXT0 && !ext_pulse[0]
		|=> !regs_q[REG_CTL0][B_EXT0_REQ])
		else $error("line 0 flag kept after service");
	a_members_kept: assert property (@(posedge clk) disable iff (!rst_n)
		accept && arb.idx == SRC_GRP0 && !bus_wr
		|=> regs_q[REG_GTMR] == $past(regs_q[REG_GTMR]))
		else $error("member flags touched by service");
	a_edge_sets: assert property (@(posedge clk) disable iff (!rst_n)
		ext_pulse[1] |=> regs_q[REG_CTL0][B_EXT1_REQ] ##1 1'b1)
		else $error("line 1 edge lost");
	a_wake_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(regs_q[REG_CTL2][B_CONV_REQ]) |-> wake)
		else $error("no wake on new flag");
	a_bus_ack: assert property (@(posedge clk) disable iff (!rst_n)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing");

endmodule : interrupt_request_controller

/* File: hdl/irq_arbiter.sv */
`timescale 1ns/1ns
module irq_arbiter (
	arb_if.arbiter arb
);
	import irq_ctrl_pkg::*;

	// fixed order; scanning downward leaves the lowest index standing
	always_comb begin
		arb.grant = '0;
		arb.idx   = '0;
		arb.valid = 1'b0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (arb.pend[i]) begin
				arb.grant = '0;
				arb.grant[i] = 1'b1;
				arb.idx   = IDX_W'(i);
				arb.valid = 1'b1;
			end
		end
	end

endmodule : irq_arbiter

/* File: hdl/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;

	// ********************************
	// sizes
	// ********************************
	localparam int NREG  = 7;
	localparam int REG_W = 8;
	localparam int NSRC  = 9;
	localparam int IDX_W = 4;
	localparam int WB_AW = 8;

	// ********************************
	// register map, byte address = index * 4
	// ********************************
	localparam logic [2:0] REG_EDGE = 3'h0;
	localparam logic [2:0] REG_CTL0 = 3'h1;
	localparam logic [2:0] REG_CTL1 = 3'h2;
	localparam logic [2:0] REG_CTL2 = 3'h3;
	localparam logic [2:0] REG_GTMR = 3'h4;
	localparam logic [2:0] REG_GPWA = 3'h5;
	localparam logic [2:0] REG_GPWB = 3'h6;
	localparam logic [7:0] REG_RESET = 8'h00;

	// implemented bits; the rest read zero
	localparam logic [7:0] IMPL_MASK [NREG] = '{
		8'h0F, 8'h7F, 8'hFF, 8'h33, 8'hFF, 8'hFF, 8'h33};
	// request flag bits of each register
	localparam logic [7:0] FLAG_MASK [NREG] = '{
		8'h00, 8'h70, 8'hF0, 8'h30, 8'hF0, 8'hF0, 8'h30};

	// ********************************
	// field positions
	// ********************************
	localparam int B_LINE0_SEL = 0;
	localparam int B_LINE1_SEL = 2;
	localparam int B_GIE       = 0;
	localparam int B_EXT0_EN   = 1;
	localparam int B_EXT1_EN   = 2;
	localparam int B_GRP0_EN   = 3;
	localparam int B_EXT0_REQ  = 4;
	localparam int B_EXT1_REQ  = 5;
	localparam int B_GRP0_REQ  = 6;
	localparam int B_TICK0_EN  = 0;
	localparam int B_TICK1_EN  = 1;
	localparam int B_GRP1_EN   = 2;
	localparam int B_GRP2_EN   = 3;
	localparam int B_TICK0_REQ = 4;
	localparam int B_TICK1_REQ = 5;
	localparam int B_GRP1_REQ  = 6;
	localparam int B_GRP2_REQ  = 7;
	localparam int B_CONV_EN   = 0;
	localparam int B_LOW_EN    = 1;
	localparam int B_CONV_REQ  = 4;
	localparam int B_LOW_REQ   = 5;
	localparam int B_MEM_REQ   = 4;

	// ********************************
	// sources in priority order, lowest index wins
	// ********************************
	localparam logic [IDX_W-1:0] SRC_EXT0  = 4'h0;
	localparam logic [IDX_W-1:0] SRC_EXT1  = 4'h1;
	localparam logic [IDX_W-1:0] SRC_GRP0  = 4'h2;
	localparam logic [IDX_W-1:0] SRC_TICK0 = 4'h3;
	localparam logic [IDX_W-1:0] SRC_TICK1 = 4'h4;
	localparam logic [IDX_W-1:0] SRC_GRP1  = 4'h5;
	localparam logic [IDX_W-1:0] SRC_GRP2  = 4'h6;
	localparam logic [IDX_W-1:0] SRC_CONV  = 4'h7;
	localparam logic [IDX_W-1:0] SRC_LOW   = 4'h8;

	localparam logic [1:0] EDGE_OFF  = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_CALL = 2'h2
	} call_state_t;

	// grouped register: flags in 7:4 pair with enables in 3:0
	function automatic logic member_pending(input logic [7:0] r);
		member_pending = |(r[7:4] & r[3:0]);
	endfunction : member_pending

endpackage : irq_ctrl_pkg

/* File: testbench/core_model.sv */
`timescale 1ns/1ns
// ********************************
// core sequencer seen by the controller
// ********************************
module core_model #(
	parameter int          DEPTH   = 1,
	parameter int          ACK_DLY = 2,
	parameter logic [15:0] PC      = 16'h0123
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        call_req,
	input  wire logic        stack_push,
	input  wire logic        stack_pop,
	input  wire logic        ret_go,
	input  wire logic        hold,
	output logic             call_ack,
	output logic             core_ready,
	output logic      [15:0] pc_next,
	output logic             stack_full,
	output logic             return_from_irq_instr
);
	logic [3:0] lvl_q, lvl_d;
	logic [3:0] cnt_q, cnt_d;

	always_comb begin
		lvl_d = lvl_q;
		if (stack_push)
			lvl_d = lvl_d + 4'h1;
		if (stack_pop)
			lvl_d = lvl_d - 4'h1;
		cnt_d = call_req ? cnt_q + 4'h1 : 4'h0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl_q <= 4'h0;
			cnt_q <= 4'h0;
		end else begin
			lvl_q <= lvl_d;
			cnt_q <= cnt_d;
		end
	end

	// slow core: takes the vector a few cycles late
	assign call_ack              = call_req && (cnt_q == 4'(ACK_DLY));
	assign stack_full            = (lvl_q == 4'(DEPTH));
	// a busy core must hold off acceptance, so the bench can stall it
	assign core_ready            = ~hold;
	assign pc_next               = PC;
	assign return_from_irq_instr = ret_go;
endmodule : core_model

/* File: testbench/interrupt_request_controller_tb.sv */
`timescale 1ns/1ns
module interrupt_request_controller_tb;
	import irq_ctrl_pkg::*;
	localparam logic [15:0] VB  = 16'h0004;
	localparam logic [15:0] VS  = 16'h0004;
	localparam logic [15:0] PCV = 16'h0123;
	logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i, timer_match_evt;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [1:0] ext_irq_pin;
	logic tick0_evt, tick1_evt, low_supply_evt, conv_done_evt;
	logic pulse_period_evt, core_ready, call_ack, stack_full;
	logic [4:0] pulse_duty_evt;
	logic [15:0] pc_next, call_vector, push_data;
	logic return_from_irq_instr, call_req, stack_push, stack_pop;
	logic wake, ret_go, hold;
	int fail_count = 0;
	int comparisons = 0;
	int wake_n = 0;

	interrupt_request_controller #(.PC_W(16), .VEC_BASE(VB),
		.VEC_STEP(VS)) dut (.clk, .rst_n, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .ext_irq_pin, .tick0_evt, .tick1_evt,
		.low_supply_evt, .conv_done_evt, .timer_match_evt,
		.pulse_period_evt, .pulse_duty_evt, .core_ready, .call_ack,
		.pc_next, .stack_full, .return_from_irq_instr, .call_req,
		.call_vector, .stack_push, .push_data, .stack_pop, .wake);
	core_model #(.DEPTH(1), .ACK_DLY(2), .PC(PCV)) core (.clk,
		.rst_n, .call_req, .stack_push, .stack_pop, .ret_go, .hold,
		.call_ack, .core_ready, .pc_next, .stack_full,
		.return_from_irq_instr);

	always #5 clk = ~clk;
	always @(posedge clk)
		if (wake === 1'b1)
			wake_n <= wake_n + 1;

	// ********************************
	// helpers
	// ********************************
	task automatic end_of_test;
		$display("checks %0d bad %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic timeout;
		fail_count++;
		end_of_test();
	endtask : timeout

	// one classic cycle, released only after ack is sampled
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			timeout();
		q = wb_dat_o[7:0];
		if (!w)
			chk(wb_dat_o[31:8], 24'h0);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask : rc

	task automatic nocall(input int n);
		int k;
		k = 0;
		repeat (n) begin
			@(posedge clk);
			if (call_req !== 1'b0)
				k++;
		end
		chk(k, 0);
	endtask : nocall

	task automatic wcall(input logic [3:0] idx);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (call_req !== 1'b1 && n < 20);
		if (n >= 20)
			timeout();
		chk(stack_push, 1);
		chk(call_vector, VB + 16'(idx) * VS);
		chk(push_data, PCV);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (call_req !== 1'b0 && n < 20);
		if (n >= 20)
			timeout();
	endtask : wcall

	task automatic ret;
		@(posedge clk);
		ret_go <= 1'b1;
		@(posedge clk);
		ret_go <= 1'b0;
		@(posedge clk);
		chk(stack_pop, 1);
	endtask : ret

	// ********************************
	// scenarios
	// ********************************
	task automatic t_regs;
		logic [7:0] e;
		for (int i = 0; i < 7; i++)
			rc(8'(i * 4), 8'h00);
		for (int i = 0; i < 7; i++) begin
			e = (i == 1) ? 8'h7E : 8'hFF;
			wr(8'(i * 4), e);
			rc(8'(i * 4), e & IMPL_MASK[i]);
		end
		wr(8'h1C, 8'hFF);
		rc(8'h1C, 8'h00);
		// members first, else group flags come straight back
		for (int i = 6; i >= 0; i--)
			wr(8'(i * 4), 8'h00);
		// a write without its byte lane must be dropped
		wb_sel_i <= 4'h0;
		wr(8'h08, 8'hFF);
		wb_sel_i <= 4'h1;
		rc(8'h08, 8'h00);
		$display("registers done");
	endtask : t_regs

	task automatic t_edge;
		logic [7:0] q;
		int w0;
		for (int ln = 0; ln < 2; ln++)
			for (int c = 0; c < 4; c++) begin
				wr(8'h00, 8'(c << (2 * ln)));
				w0 = wake_n;
				@(posedge clk);
				ext_irq_pin[ln] <= 1'b1;
				repeat (3) @(posedge clk);
				bus(1'b0, 8'h04, 8'h00, q);
				chk(q[4 + ln], c[0]);
				chk(wake_n != w0, c[0]);
				wr(8'h04, 8'h00);
				@(posedge clk);
				ext_irq_pin[ln] <= 1'b0;
				repeat (3) @(posedge clk);
				bus(1'b0, 8'h04, 8'h00, q);
				chk(q[4 + ln], c[1]);
				wr(8'h04, 8'h00);
			end
		// serviced line 0 request clears its own flag
		wr(8'h00, 8'h01);
		wr(8'h04, 8'h03);
		@(posedge clk);
		ext_irq_pin[0] <= 1'b1;
		wcall(SRC_EXT0);
		rc(8'h04, 8'h02);
		ret();
		@(posedge clk);
		ext_irq_pin[0] <= 1'b0;
		wr(8'h00, 8'h00);
		$display("edges done");
	endtask : t_edge

	task automatic t_call;
		@(posedge clk);
		tick0_evt <= 1'b1;
		@(posedge clk);
		tick0_evt <= 1'b0;
		rc(8'h08, 8'h10);
		wr(8'h04, 8'h01);
		nocall(10);
		hold <= 1'b1;
		wr(8'h08, 8'h11);
		nocall(6);
		hold <= 1'b0;
		wcall(SRC_TICK0);
		rc(8'h04, 8'h00);
		rc(8'h08, 8'h01);
		ret();
		$display("call done");
	endtask : t_call

	task automatic t_prio;
		@(posedge clk);
		tick1_evt      <= 1'b1;
		conv_done_evt  <= 1'b1;
		low_supply_evt <= 1'b1;
		@(posedge clk);
		tick1_evt      <= 1'b0;
		conv_done_evt  <= 1'b0;
		low_supply_evt <= 1'b0;
		wr(8'h0C, 8'h33);
		wr(8'h08, 8'h22);
		nocall(5);
		wr(8'h04, 8'h01);
		wcall(SRC_TICK1);
		wr(8'h04, 8'h01);
		nocall(10);
		ret();
		wcall(SRC_CONV);
		ret();
		wr(8'h04, 8'h01);
		wcall(SRC_LOW);
		ret();
		rc(8'h0C, 8'h03);
		$display("priority done");
	endtask : t_prio

	task automatic t_group;
		wr(8'h10, 8'h01);
		@(posedge clk);
		timer_match_evt  <= 4'hF;
		pulse_period_evt <= 1'b1;
		pulse_duty_evt   <= 5'h1F;
		@(posedge clk);
		timer_match_evt  <= 4'h0;
		pulse_period_evt <= 1'b0;
		pulse_duty_evt   <= 5'h00;
		rc(8'h10, 8'hF1);
		rc(8'h14, 8'hF0);
		rc(8'h18, 8'h30);
		rc(8'h04, 8'h40);
		rc(8'h08, 8'h02);
		wr(8'h04, 8'h09);
		wcall(SRC_GRP0);
		rc(8'h10, 8'hF1);
		ret();
		wr(8'h10, 8'h00);
		wr(8'h14, 8'h00);
		wr(8'h18, 8'h00);
		wr(8'h04, 8'h00);
		rc(8'h04, 8'h00);
		$display("group done");
	endtask : t_group

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, ret_go, hold} = 5'h00;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h0;
		ext_irq_pin = 2'h0;
		{tick0_evt, tick1_evt, low_supply_evt, conv_done_evt} = 4'h0;
		timer_match_evt = 4'h0;
		pulse_period_evt = 1'b0;
		pulse_duty_evt = 5'h00;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_edge();
		t_call();
		t_prio();
		t_group();
		end_of_test();
	end
endmodule : interrupt_request_controller_tb
